// File: inc/amctc_pkg.sv
// Package for the converter mode, channel and trigger control block.
// Assumes a 32-bit classic Wishbone register bus and a single 125 MHz clock.
package amctc_pkg;

  // Bus geometry.
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned REG_W = 8;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFS_CTRL_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_TRIG_SCAN = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_RESULT_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] RESULT_AREA_MASK = 8'hF0;
  localparam int unsigned RESULT_IDX_LSB = 2;

  // Control/status register fields.
  localparam int unsigned CS_END_FLAG_BIT = 7;
  localparam int unsigned CS_IRQ_EN_BIT = 6;
  localparam int unsigned CS_START_BIT = 5;
  localparam int unsigned CS_MULTI_BIT = 4;
  localparam int unsigned CS_CTS_BIT = 3;
  localparam int unsigned CS_CH_LSB = 0;
  localparam int unsigned CH_W = 3;
  localparam logic [REG_W-1:0] CS_RESET = 8'h00;

  // Trigger/scan control register fields.
  localparam int unsigned TS_TRIG_LSB = 6;
  localparam int unsigned TS_SCAN_BIT = 5;
  localparam logic [1:0] TRIG_EXT_CODE = 2'h3;
  localparam logic [REG_W-1:0] TS_READS_ONE = 8'h07;
  localparam logic [REG_W-1:0] TS_RESET = 8'h07;

  // Interrupt status and mask fields.
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned IRQ_END_BIT = 0;
  localparam int unsigned IRQ_TRIG_BIT = 1;

  // Conversion timing: one state is one peripheral clock period.
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned STATE_PERIOD_NS = 8;
  localparam int unsigned CONV_STATES_SLOW = 536;
  localparam int unsigned CONV_STATES_FAST = 266;
  localparam int unsigned CONV_CYC_SLOW = (CONV_STATES_SLOW * STATE_PERIOD_NS) / CLK_PERIOD_NS;
  localparam int unsigned CONV_CYC_FAST = (CONV_STATES_FAST * STATE_PERIOD_NS) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 10;

  // Converter data.
  localparam int unsigned RESULT_W = 10;
  localparam int unsigned NUM_INPUTS = 4;
  localparam int unsigned CHSEL_W = 2;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'b00,
    MODE_MULTI = 2'b01,
    MODE_SCAN = 2'b10
  } amctc_mode_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_CONV = 1'b1
  } amctc_state_t;

endpackage

// File: src/amctc_result_mem.sv
// Small result store, one word per analog input, with a registered read port.
// Assumes write and read addresses are stable around the clock edge.
`timescale 1ns/10ps
`default_nettype none
module amctc_result_mem #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 4,
  parameter int unsigned AW = 2
) (
  // Clock.
  input wire logic clk_i,
  // Write port.
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  // Read port.
  input wire logic [AW-1:0] rd_addr_i,
  output logic [WIDTH-1:0] rd_data_o
);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [WIDTH-1:0] rd_data_ff;

  if (DEPTH > (1 << AW)) begin : g_bad_depth
    $error("Result store depth does not fit its address width.");
  end

  // Results are not reset; software reads them only after a conversion.
  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem_ff[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    rd_data_ff <= mem_ff[rd_addr_i];
  end

  assign rd_data_o = rd_data_ff;

endmodule
`default_nettype wire

// File: src/amctc_top.sv
// Mode, channel and trigger control for a 10-bit successive-approximation converter.
// Assumes a classic Wishbone master, synchronous inputs and an analog core that
// presents the sampled code on adc_data_i by the end of each conversion period.
//
// Notes on behaviour
// - An 8-bit control/status register holds the multi bit, the time select and a 3-bit channel field, all zero after reset.
// - The scan bit at bit 5 of the trigger/scan register picks multi (0) or scan (1) only while multi is set.
// - A conversion lasts at most 536 states with the time select clear and at most 266 states with it set.
// - In single mode channel codes 000 to 011 convert input 0 to input 3 respectively.
// - In multi and scan modes codes 000 to 011 convert inputs 0 up to 0, 1, 2 or 3, starting at input 0.
// - The 8-bit trigger/scan register returns to 07 hex on reset and on entry to standby.
// - Only with both trigger enables set does a falling trigger edge start conversion; other codes ignore the pin.
// - Bits 4 and 3 of the trigger/scan register always read 0 and software writes only 0 there.
// - Bits 2 to 0 of the trigger/scan register are read-only ones and software writes 0 there.
// - A write can only clear the conversion-end flag, never set it.
// - The start bit at bit 5 of the control/status register starts or stops conversion, stays 1 while running and can be set by the trigger.
// - Each conversion stores a 10-bit result in the data register of the converted input.
`timescale 1ns/10ps
`default_nettype none
module amctc_top #(
  parameter int unsigned RESULT_W = amctc_pkg::RESULT_W,
  parameter int unsigned NUM_INPUTS = amctc_pkg::NUM_INPUTS,
  parameter int unsigned CONV_CYC_SLOW = amctc_pkg::CONV_CYC_SLOW,
  parameter int unsigned CONV_CYC_FAST = amctc_pkg::CONV_CYC_FAST
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Power management.
  input wire logic standby_i,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [amctc_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [amctc_pkg::DATA_W/8-1:0] wb_sel_i,
  input wire logic [amctc_pkg::DATA_W-1:0] wb_dat_i,
  output logic [amctc_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Analog core side.
  input wire logic external_trigger_pin_i,
  input wire logic [RESULT_W-1:0] adc_data_i,
  output logic [amctc_pkg::CHSEL_W-1:0] analog_channel_o,
  output logic conv_active_o,
  // Interrupt.
  output logic irq_o
);

  if (NUM_INPUTS != (1 << amctc_pkg::CHSEL_W)) begin : g_bad_inputs
    $error("The channel decoder serves exactly four analog inputs.");
  end
  if (RESULT_W > amctc_pkg::DATA_W) begin : g_bad_width
    $error("Result width exceeds the bus data width.");
  end
  if ((CONV_CYC_SLOW < 1) || (CONV_CYC_FAST < 1) ||
      (CONV_CYC_SLOW > (1 << amctc_pkg::CNT_W)) ||
      (CONV_CYC_FAST > (1 << amctc_pkg::CNT_W))) begin : g_bad_time
    $error("Conversion period does not fit the period counter.");
  end

  localparam logic [amctc_pkg::CNT_W-1:0] LEN_SLOW = amctc_pkg::CNT_W'(CONV_CYC_SLOW - 1);
  localparam logic [amctc_pkg::CNT_W-1:0] LEN_FAST = amctc_pkg::CNT_W'(CONV_CYC_FAST - 1);
  localparam logic [amctc_pkg::CNT_W-1:0] CNT_ZERO = 10'h000;
  localparam logic [amctc_pkg::CNT_W-1:0] CNT_ONE = 10'h001;
  localparam logic [amctc_pkg::CHSEL_W-1:0] CH_FIRST = 2'h0;
  localparam logic [amctc_pkg::CHSEL_W-1:0] CH_STEP = 2'h1;

  // Control/status register fields.
  logic end_flag_ff;
  logic irq_en_ff;
  logic start_ff;
  logic multi_ff;
  logic cts_ff;
  logic [amctc_pkg::CH_W-1:0] ch_field_ff;
  logic flag_seen_ff;

  // Trigger/scan register fields.
  logic [1:0] trig_en_ff;
  logic scan_ff;

  // Interrupt registers.
  logic [amctc_pkg::IRQ_W-1:0] irq_status_ff;
  logic [amctc_pkg::IRQ_W-1:0] irq_mask_ff;
  logic irq_ff;

  // Sequencer.
  amctc_pkg::amctc_state_t state_ff;
  logic [amctc_pkg::CHSEL_W-1:0] cur_ch_ff;
  logic [amctc_pkg::CNT_W-1:0] cnt_ff;
  logic active_ff;

  // Trigger synchroniser and edge detector.
  logic trig_meta_ff;
  logic trig_sync_ff;
  logic trig_prev_ff;

  // Bus slave.
  logic busy_ff;
  logic ack_ff;
  logic [amctc_pkg::DATA_W-1:0] dat_ff;

  logic [RESULT_W-1:0] mem_rd_data;
  logic [amctc_pkg::CHSEL_W-1:0] mem_rd_idx;

  // Bus decode.
  logic commit;
  logic wr;
  logic rd;
  logic hit_cs;
  logic hit_ts;
  logic hit_ist;
  logic hit_imk;
  logic hit_res;
  logic [amctc_pkg::REG_W-1:0] wr_byte;

  assign commit = busy_ff & ~ack_ff;
  assign wr = commit & wb_we_i & wb_sel_i[0];
  assign rd = commit & ~wb_we_i;
  assign wr_byte = wb_dat_i[amctc_pkg::REG_W-1:0];
  assign hit_cs = (wb_adr_i == amctc_pkg::OFS_CTRL_STATUS);
  assign hit_ts = (wb_adr_i == amctc_pkg::OFS_TRIG_SCAN);
  assign hit_ist = (wb_adr_i == amctc_pkg::OFS_IRQ_STATUS);
  assign hit_imk = (wb_adr_i == amctc_pkg::OFS_IRQ_MASK);
  assign hit_res = ((wb_adr_i & amctc_pkg::RESULT_AREA_MASK) == amctc_pkg::OFS_RESULT_BASE);
  assign mem_rd_idx = wb_adr_i[amctc_pkg::RESULT_IDX_LSB +: amctc_pkg::CHSEL_W];

  // Mode and sequencing decode.
  amctc_pkg::amctc_mode_t mode;
  logic trig_fall;
  logic trig_go;
  logic conv_done;
  logic is_last;
  logic group_end;
  logic seq_end;
  logic [amctc_pkg::CHSEL_W-1:0] ch_code;

  always_comb begin
    if (!multi_ff) begin
      mode = amctc_pkg::MODE_SINGLE;
    end else if (scan_ff) begin
      mode = amctc_pkg::MODE_SCAN;
    end else begin
      mode = amctc_pkg::MODE_MULTI;
    end
  end

  assign ch_code = ch_field_ff[amctc_pkg::CHSEL_W-1:0];
  assign trig_fall = trig_prev_ff & ~trig_sync_ff;
  assign trig_go = trig_fall & (trig_en_ff == amctc_pkg::TRIG_EXT_CODE);
  assign conv_done = (state_ff == amctc_pkg::ST_CONV) & start_ff & (cnt_ff == CNT_ZERO);
  assign is_last = (mode == amctc_pkg::MODE_SINGLE) | (cur_ch_ff == ch_code);
  assign group_end = conv_done & is_last;
  assign seq_end = group_end & (mode != amctc_pkg::MODE_SCAN);

  // Trigger pin: the first stage feeds only the second.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_meta_ff <= 1'b1;
      trig_sync_ff <= 1'b1;
      trig_prev_ff <= 1'b1;
    end else begin
      trig_meta_ff <= external_trigger_pin_i;
      trig_sync_ff <= trig_meta_ff;
      trig_prev_ff <= trig_sync_ff;
    end
  end

  // Control fields that only software steers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_en_ff <= amctc_pkg::CS_RESET[amctc_pkg::CS_IRQ_EN_BIT];
      multi_ff <= amctc_pkg::CS_RESET[amctc_pkg::CS_MULTI_BIT];
      cts_ff <= amctc_pkg::CS_RESET[amctc_pkg::CS_CTS_BIT];
      ch_field_ff <= amctc_pkg::CS_RESET[amctc_pkg::CS_CH_LSB +: amctc_pkg::CH_W];
    end else if (wr && hit_cs) begin
      irq_en_ff <= wr_byte[amctc_pkg::CS_IRQ_EN_BIT];
      multi_ff <= wr_byte[amctc_pkg::CS_MULTI_BIT];
      cts_ff <= wr_byte[amctc_pkg::CS_CTS_BIT];
      ch_field_ff <= wr_byte[amctc_pkg::CS_CH_LSB +: amctc_pkg::CH_W];
    end
  end

  // Start bit: software, trigger, sequence end and standby all act on it.
  // Changing the time select or channel mid-run is only safe after a stop.
  always_ff @(posedge clk_i) begin
    if (rst_i || standby_i) begin
      start_ff <= 1'b0;
    end else if (trig_go) begin
      start_ff <= 1'b1;
    end else if (wr && hit_cs) begin
      start_ff <= wr_byte[amctc_pkg::CS_START_BIT];
    end else if (seq_end) begin
      start_ff <= 1'b0;
    end
  end

  // End flag: hardware set wins over a clearing write in the same cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      end_flag_ff <= amctc_pkg::CS_RESET[amctc_pkg::CS_END_FLAG_BIT];
      flag_seen_ff <= 1'b0;
    end else if (group_end) begin
      end_flag_ff <= 1'b1;
      flag_seen_ff <= flag_seen_ff;
    end else if (wr && hit_cs && !wr_byte[amctc_pkg::CS_END_FLAG_BIT] && flag_seen_ff) begin
      end_flag_ff <= 1'b0;
      flag_seen_ff <= 1'b0;
    end else if (rd && hit_cs && end_flag_ff) begin
      flag_seen_ff <= 1'b1;
    end
  end

  // Trigger/scan register; the constant bits are never stored.
  always_ff @(posedge clk_i) begin
    if (rst_i || standby_i) begin
      trig_en_ff <= amctc_pkg::TS_RESET[amctc_pkg::TS_TRIG_LSB +: 2];
      scan_ff <= amctc_pkg::TS_RESET[amctc_pkg::TS_SCAN_BIT];
    end else if (wr && hit_ts) begin
      trig_en_ff <= wr_byte[amctc_pkg::TS_TRIG_LSB +: 2];
      scan_ff <= wr_byte[amctc_pkg::TS_SCAN_BIT];
    end
  end

  // Sequencer: a cleared start bit aborts at once, so a restart begins afresh.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= amctc_pkg::ST_IDLE;
      cur_ch_ff <= CH_FIRST;
      cnt_ff <= CNT_ZERO;
    end else begin
      case (state_ff)
        amctc_pkg::ST_IDLE: begin
          if (start_ff) begin
            state_ff <= amctc_pkg::ST_CONV;
            cnt_ff <= cts_ff ? LEN_FAST : LEN_SLOW;
            if (mode == amctc_pkg::MODE_SINGLE) begin
              cur_ch_ff <= ch_code;
            end else begin
              cur_ch_ff <= CH_FIRST;
            end
          end
        end
        amctc_pkg::ST_CONV: begin
          if (!start_ff) begin
            state_ff <= amctc_pkg::ST_IDLE;
          end else if (conv_done) begin
            cnt_ff <= cts_ff ? LEN_FAST : LEN_SLOW;
            if (!is_last) begin
              cur_ch_ff <= cur_ch_ff + CH_STEP;
            end else if (mode == amctc_pkg::MODE_SCAN) begin
              cur_ch_ff <= CH_FIRST;
            end else begin
              state_ff <= amctc_pkg::ST_IDLE;
            end
          end else begin
            cnt_ff <= cnt_ff - CNT_ONE;
          end
        end
        default: begin
          state_ff <= amctc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_ff <= 1'b0;
    end else begin
      active_ff <= (state_ff == amctc_pkg::ST_CONV) & start_ff & ~seq_end;
    end
  end

  // The result of each finished conversion lands in its own input's slot.
  amctc_result_mem #(
    .WIDTH(RESULT_W),
    .DEPTH(NUM_INPUTS),
    .AW(amctc_pkg::CHSEL_W)
  ) u_result_mem (
    .clk_i(clk_i),
    .wr_en_i(conv_done),
    .wr_addr_i(cur_ch_ff),
    .wr_data_i(adc_data_i),
    .rd_addr_i(mem_rd_idx),
    .rd_data_o(mem_rd_data)
  );

  // Interrupt status: each bit sticky, cleared by writing one, set wins.
  logic [amctc_pkg::IRQ_W-1:0] irq_event;
  logic [amctc_pkg::IRQ_W-1:0] irq_gate;

  assign irq_event[amctc_pkg::IRQ_END_BIT] = group_end;
  assign irq_event[amctc_pkg::IRQ_TRIG_BIT] = trig_go;
  assign irq_gate[amctc_pkg::IRQ_END_BIT] = irq_en_ff;
  assign irq_gate[amctc_pkg::IRQ_TRIG_BIT] = 1'b1;

  for (genvar i = 0; i < amctc_pkg::IRQ_W; i++) begin : g_irq
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        irq_status_ff[i] <= 1'b0;
      end else if (irq_event[i]) begin
        irq_status_ff[i] <= 1'b1;
      end else if (wr && hit_ist && wr_byte[i]) begin
        irq_status_ff[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_ff <= '0;
    end else if (wr && hit_imk) begin
      irq_mask_ff <= wr_byte[amctc_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(irq_status_ff & irq_mask_ff & irq_gate);
    end
  end

  // Read data assembly.
  logic [amctc_pkg::REG_W-1:0] cs_rd;
  logic [amctc_pkg::REG_W-1:0] ts_rd;
  logic [amctc_pkg::DATA_W-1:0] nxt_dat;

  always_comb begin
    cs_rd = '0;
    cs_rd[amctc_pkg::CS_END_FLAG_BIT] = end_flag_ff;
    cs_rd[amctc_pkg::CS_IRQ_EN_BIT] = irq_en_ff;
    cs_rd[amctc_pkg::CS_START_BIT] = start_ff;
    cs_rd[amctc_pkg::CS_MULTI_BIT] = multi_ff;
    cs_rd[amctc_pkg::CS_CTS_BIT] = cts_ff;
    cs_rd[amctc_pkg::CS_CH_LSB +: amctc_pkg::CH_W] = ch_field_ff;
    ts_rd = amctc_pkg::TS_READS_ONE;
    ts_rd[amctc_pkg::TS_TRIG_LSB +: 2] = trig_en_ff;
    ts_rd[amctc_pkg::TS_SCAN_BIT] = scan_ff;
  end

  always_comb begin
    nxt_dat = '0;
    if (hit_cs) begin
      nxt_dat[amctc_pkg::REG_W-1:0] = cs_rd;
    end else if (hit_ts) begin
      nxt_dat[amctc_pkg::REG_W-1:0] = ts_rd;
    end else if (hit_ist) begin
      nxt_dat[amctc_pkg::IRQ_W-1:0] = irq_status_ff;
    end else if (hit_imk) begin
      nxt_dat[amctc_pkg::IRQ_W-1:0] = irq_mask_ff;
    end else if (hit_res) begin
      nxt_dat[RESULT_W-1:0] = mem_rd_data;
    end
  end

  // Bus handshake: two cycles to ack, which gives the result store time for
  // its registered read without a separate wait path for that area.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_ff <= 1'b0;
      ack_ff <= 1'b0;
    end else begin
      busy_ff <= wb_cyc_i & wb_stb_i & ~busy_ff & ~ack_ff;
      ack_ff <= commit;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_ff <= '0;
    end else if (rd) begin
      dat_ff <= nxt_dat;
    end
  end

  assign wb_dat_o = dat_ff;
  assign wb_ack_o = ack_ff;
  assign analog_channel_o = cur_ch_ff;
  assign conv_active_o = active_ff;
  assign irq_o = irq_ff;

endmodule
`default_nettype wire

// File: dv/amctc_top_monitor.sv
// Checker for the converter control block, seeing only its top ports.
// Assumes one clock domain and a synchronous active high reset.
`timescale 1ns/10ps
`default_nettype none
module amctc_top_monitor #(
  parameter int unsigned CONV_CYC_FAST = 4
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic standby_i,
  // Register bus.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [amctc_pkg::DATA_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Converter side.
  input wire logic [amctc_pkg::CHSEL_W-1:0] analog_channel_o,
  input wire logic conv_active_o,
  input wire logic irq_o
);
  logic [9:0] run_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Length of the present run of activity, so short conversions are caught.
  always_ff @(posedge clk_i) begin
    if (rst_i || !conv_active_o) begin
      run_ff <= 10'h000;
    end else begin
      run_ff <= run_ff + 10'h001;
    end
  end

  property p_reset_quiet;
    $fell(rst_i) |-> !wb_ack_o && !irq_o && !conv_active_o && analog_channel_o == 2'h0;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
  property p_ack_late;
    $rose(wb_cyc_i && wb_stb_i) |-> !wb_ack_o ##[1:2] wb_ack_o;
  endproperty
  a_ack_late: assert property (p_ack_late) else $error("bus answer late or early");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("bus answer longer than one cycle");
  property p_ack_cause;
    wb_ack_o |-> wb_cyc_i && wb_stb_i && $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("bus answer without request");
  property p_rdata_hold;
    $changed(wb_dat_o) |-> wb_ack_o && !wb_we_i;
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved outside a read");
  property p_standby_stop;
    standby_i [*4] |-> !conv_active_o;
  endproperty
  a_standby_stop: assert property (p_standby_stop) else $error("converting in standby");
  property p_conv_len;
    $fell(conv_active_o) |-> run_ff >= CONV_CYC_FAST - 1;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion too short");
  property p_chan_hold;
    $rose(conv_active_o) |-> $stable(analog_channel_o) [*2];
  endproperty
  a_chan_hold: assert property (p_chan_hold) else $error("input moved in a conversion");
endmodule
`default_nettype wire

// File: dv/amctc_partner.sv
// Analog inputs and external trigger source facing the converter block.
// Assumes the trigger line idles high through a pull-up.
`timescale 1ns/10ps
`default_nettype none
module amctc_partner (
  // Clock.
  input wire logic clk_i,
  // Analog inputs.
  input wire logic [1:0] analog_channel_i,
  output logic [9:0] adc_data_o,
  // Trigger source.
  input wire logic fire_i,
  output logic external_trigger_pin_o
);
  logic [2:0] low_ff = 3'h0;

  // Each input carries its own level, so a swapped input shows in the result.
  assign adc_data_o = 10'h3C3 - 10'h111 * {8'h00, analog_channel_i};

  always_ff @(posedge clk_i) begin
    if (fire_i) begin
      low_ff <= 3'h4;
    end else if (low_ff != 3'h0) begin
      low_ff <= low_ff - 3'h1;
    end
  end
  assign external_trigger_pin_o = (low_ff == 3'h0);
endmodule
`default_nettype wire

// File: dv/amctc_top_tb.sv
// Self-checking bench for the converter control block.
// Assumes the block answers the bus and converts with shortened periods.
`timescale 1ns/10ps
`default_nettype none
module amctc_top_tb;
  localparam int unsigned SLOW = 8;
  localparam int unsigned FAST = 4;
  localparam logic [9:0] CODE [4] = '{10'h3C3, 10'h2B2, 10'h1A1, 10'h090};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic standby_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, pin, irq_o, act, fire = 1'b0;
  logic [9:0] adc;
  logic [1:0] chan;
  int fails = 0;
  int compares = 0;

  always #4 clk_i = ~clk_i;

  amctc_top #(.CONV_CYC_SLOW(SLOW), .CONV_CYC_FAST(FAST)) DUT (.clk_i(clk_i), .rst_i(rst_i),
    .standby_i(standby_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .external_trigger_pin_i(pin), .adc_data_i(adc),
    .analog_channel_o(chan), .conv_active_o(act), .irq_o(irq_o));
  amctc_partner PRT (.clk_i(clk_i), .analog_channel_i(chan), .adc_data_o(adc),
    .fire_i(fire), .external_trigger_pin_o(pin));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= {24'h00_0000, wd};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    chk({31'h0, wb_ack_o}, 32'h0000_0001, "bus answer");
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] wd);
    logic [31:0] d;
    bus(1'b1, adr, wd, d);
  endtask

  task automatic rdc(input logic [7:0] adr, input logic [31:0] exp, input string what);
    logic [31:0] d;
    bus(1'b0, adr, 8'h00, d);
    chk(d, exp, what);
  endtask

  task automatic wait_act(input logic lvl, output int n);
    n = 0;
    while (act !== lvl && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    chk({31'h0, act}, {31'h0, lvl}, "activity");
  endtask

  task automatic pulse_fire();
    @(posedge clk_i);
    fire <= 1'b1;
    @(posedge clk_i);
    fire <= 1'b0;
  endtask

  task automatic t_reset();
    rdc(8'h00, 32'h0000_0000, "ctrl reset");
    rdc(8'h04, 32'h0000_0007, "trig reset");
    rdc(8'h08, 32'h0000_0000, "irq status reset");
    rdc(8'h0C, 32'h0000_0000, "irq mask reset");
    rdc(8'h20, 32'h0000_0000, "unmapped read");
  endtask

  task automatic t_regs();
    wr(8'h00, 8'hDF);
    rdc(8'h00, 32'h0000_005F, "ctrl write");
    wr(8'h00, 8'h00);
    wr(8'h04, 8'hE0);
    rdc(8'h04, 32'h0000_00E7, "trig fixed bits");
    wr(8'h04, 8'h00);
    rdc(8'h04, 32'h0000_0007, "trig cleared");
  endtask

  task automatic t_single();
    logic [2:0] ch;
    logic conversion_time_select;
    int n;
    wr(8'h04, 8'h20);
    for (int c = 0; c < 4; c++) begin
      ch = c[2:0];
      conversion_time_select = c[0];
      wr(8'h00, {3'b001, 1'b0, conversion_time_select, ch});
      wait_act(1'b1, n);
      chk({30'h0, chan}, {30'h0, ch[1:0]}, "single input");
      wait_act(1'b0, n);
      // The activity output starts a cycle into the period and drops with its last cycle.
      chk(n, (conversion_time_select ? FAST : SLOW) - 1, "conversion time");
      rdc(8'h00, {24'h0, 3'b100, 1'b0, conversion_time_select, ch}, "single end");
      rdc(8'h10 + 8'(4 * c), {22'h0, CODE[c]}, "single result");
      wr(8'h00, 8'h00);
      rdc(8'h00, 32'h0000_0000, "flag cleared");
    end
  endtask

  task automatic t_group(input logic scan, input logic [1:0] ch);
    logic [1:0] q[$];
    int n;
    wr(8'h04, {2'b00, scan, 5'h00});
    wr(8'h00, {6'b001110, ch});
    n = 0;
    while (n < 12 * FAST) begin
      @(posedge clk_i);
      n++;
      if (act === 1'b1 && (q.size() == 0 || chan !== q[$])) q.push_back(chan);
      if (!scan && q.size() > 0 && act === 1'b0) break;
    end
    chk(q.size() >= ch + 1, 1, "group length");
    if (!scan) chk(q.size(), ch + 1, "multi count");
    for (int i = 0; i < q.size(); i++) chk(q[i], i % (ch + 1), "group order");
    for (int i = 0; i <= ch; i++) rdc(8'h10 + 8'(4 * i), {22'h0, CODE[i]}, "group result");
    rdc(8'h00, {24'h0, 1'b1, 1'b0, scan, 3'b110, ch}, "group ctrl");
    wr(8'h00, {6'b000110, ch});
    wait_act(1'b0, n);
    wr(8'h00, 8'h00);
  endtask

  task automatic t_trig();
    int n;
    // Earlier runs left the end event pending; clear it so the raise below is earned.
    wr(8'h08, 8'h03);
    wr(8'h0C, 8'h03);
    wr(8'h00, 8'h43);
    for (int c = 0; c < 3; c++) begin
      wr(8'h04, {c[1:0], 6'h00});
      pulse_fire();
      repeat (12) @(posedge clk_i);
      chk(act, 1'b0, "trigger ignored");
    end
    rdc(8'h08, 32'h0000_0000, "no trigger event");
    chk(irq_o, 1'b0, "irq quiet");
    wr(8'h04, 8'hC0);
    pulse_fire();
    wait_act(1'b1, n);
    chk(n <= 12, 1, "trigger delay");
    wait_act(1'b0, n);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b1, "irq raised");
    rdc(8'h08, 32'h0000_0003, "irq status");
    rdc(8'h00, 32'h0000_00C3, "trigger end");
    wr(8'h0C, 8'h00);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b0, "irq masked");
    wr(8'h0C, 8'h03);
    wr(8'h08, 8'h03);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b0, "irq cleared");
    rdc(8'h08, 32'h0000_0000, "status cleared");
    wr(8'h00, 8'h00);
  endtask

  task automatic t_standby();
    logic [31:0] d;
    wr(8'h04, 8'hE0);
    wr(8'h00, 8'h38);
    repeat (6) @(posedge clk_i);
    standby_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    standby_i <= 1'b0;
    chk(act, 1'b0, "standby stop");
    rdc(8'h04, 32'h0000_0007, "trig after standby");
    bus(1'b0, 8'h00, 8'h00, d);
    chk(d & 32'h0000_007F, 32'h0000_0018, "start after standby");
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_regs();
    t_single();
    t_group(1'b0, 2'h2);
    t_group(1'b1, 2'h1);
    t_trig();
    t_standby();
    close_out();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    close_out();
  end
endmodule

bind amctc_top amctc_top_monitor #(.CONV_CYC_FAST(CONV_CYC_FAST)) MON (.clk_i(clk_i),
  .rst_i(rst_i), .standby_i(standby_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .analog_channel_o(analog_channel_o), .conv_active_o(conv_active_o), .irq_o(irq_o));
`default_nettype wire
